//--- core/program_erase_controller_defines.svh
// Holds register offsets, field positions, reset values and keys of the flash program/erase controller.
// Assumes a word-addressed register port with byte offsets; included by core files only.
`ifndef PROGRAM_ERASE_CONTROLLER_DEFINES_SVH
`define PROGRAM_ERASE_CONTROLLER_DEFINES_SVH

`define PROGRAM_ERASE_CONTROLLER_OFS_KEY 8'h04
`define PROGRAM_ERASE_CONTROLLER_OFS_OPTKEY 8'h08
`define PROGRAM_ERASE_CONTROLLER_OFS_STATUS 8'h0c
`define PROGRAM_ERASE_CONTROLLER_OFS_CTRL 8'h10
`define PROGRAM_ERASE_CONTROLLER_OFS_ADDR 8'h14
`define PROGRAM_ERASE_CONTROLLER_OFS_OPT 8'h1c
`define PROGRAM_ERASE_CONTROLLER_OFS_WP 8'h20
`define PROGRAM_ERASE_CONTROLLER_OFS_FASTKEY 8'h24
`define PROGRAM_ERASE_CONTROLLER_OFS_BOOTKEY 8'h28

`define PROGRAM_ERASE_CONTROLLER_KEY_FIRST 32'h45670123
`define PROGRAM_ERASE_CONTROLLER_KEY_SECOND 32'hcdef89ab

`define PROGRAM_ERASE_CONTROLLER_ST_BOOTLOCK 15
`define PROGRAM_ERASE_CONTROLLER_ST_MODE 14
`define PROGRAM_ERASE_CONTROLLER_ST_DONE 5
`define PROGRAM_ERASE_CONTROLLER_ST_PROT 4
`define PROGRAM_ERASE_CONTROLLER_ST_BUSY 0

`define PROGRAM_ERASE_CONTROLLER_CT_BUFCLR 19
`define PROGRAM_ERASE_CONTROLLER_CT_PAGE_BUFFER_LOAD 18
`define PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_ERASE_SEL 17
`define PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_PROGRAM_SEL 16
`define PROGRAM_ERASE_CONTROLLER_CT_FAST_MODE_LOCK 15
`define PROGRAM_ERASE_CONTROLLER_CT_DONEIE 12
`define PROGRAM_ERASE_CONTROLLER_CT_ERROR_IRQ_ENABLE 10
`define PROGRAM_ERASE_CONTROLLER_CT_OPTWE 9
`define PROGRAM_ERASE_CONTROLLER_CT_LOCK 7
`define PROGRAM_ERASE_CONTROLLER_CT_GO 6
`define PROGRAM_ERASE_CONTROLLER_CT_OPTION_ERASE_SEL 5
`define PROGRAM_ERASE_CONTROLLER_CT_OBPG 4
`define PROGRAM_ERASE_CONTROLLER_CT_MER 2
`define PROGRAM_ERASE_CONTROLLER_CT_PER 1
`define PROGRAM_ERASE_CONTROLLER_CT_PG 0

`define PROGRAM_ERASE_CONTROLLER_OPT_USER_BYTE_ONE_LSB 18
`define PROGRAM_ERASE_CONTROLLER_OPT_USER_BYTE_ZERO_LSB 10
`define PROGRAM_ERASE_CONTROLLER_OPT_FIXED 2'h3
`define PROGRAM_ERASE_CONTROLLER_OPT_FIXED_LSB 8
`define PROGRAM_ERASE_CONTROLLER_OPT_RSTDLY_LSB 5
`define PROGRAM_ERASE_CONTROLLER_OPT_STBY 4
`define PROGRAM_ERASE_CONTROLLER_OPT_WDG 2
`define PROGRAM_ERASE_CONTROLLER_OPT_RDP 1
`define PROGRAM_ERASE_CONTROLLER_OPT_ERR 0

`define PROGRAM_ERASE_CONTROLLER_CTRL_RESET 32'h00008080
`define PROGRAM_ERASE_CONTROLLER_STATUS_RESET 32'h00008000
`define PROGRAM_ERASE_CONTROLLER_CTRL_WMASK 32'h000f1637

`endif

//--- core/program_erase_controller_pkg.sv
// Holds the types of the flash program/erase controller.
// Assumes program_erase_controller_defines.svh is compiled alongside.
`default_nettype none
package program_erase_controller_pkg;

    typedef enum logic [1:0] {
        PROGRAM_ERASE_CONTROLLER_KEY_IDLE = 2'b00,
        PROGRAM_ERASE_CONTROLLER_KEY_HALF = 2'b01,
        PROGRAM_ERASE_CONTROLLER_KEY_DEAD = 2'b10
    } program_erase_controller_key_t;

    typedef struct packed {
        logic [7:0] user_byte_one;
        logic [7:0] user_byte_zero;
        logic [1:0] reset_delay_cfg;
        logic standby_reset_ctl;
        logic watchdog_hw_enable;
        logic read_protect_state;
        logic option_mismatch_flag;
        logic [15:0] block_protect_bits;
    } program_erase_controller_opt_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } program_erase_controller_bus_t;

    typedef struct packed {
        logic start;
        logic [31:0] addr;
        logic [31:0] data;
        logic [4:0] mode;
    } program_erase_controller_cmd_t;

    typedef struct packed {
        program_erase_controller_key_t main_key;
        program_erase_controller_key_t fast_key;
        program_erase_controller_key_t opt_key;
        program_erase_controller_key_t boot_key;
        logic boot_lock;
        logic boot_mode;
        logic done_flag;
        logic prot_flag;
        logic busy;
        logic [31:0] ctrl;
        logic [31:0] addr;
        logic [31:0] last_word;
        logic [31:0] rdata;
        logic bus_err;
        logic irq;
        program_erase_controller_cmd_t cmd;
        program_erase_controller_opt_t opt;
        logic opt_loaded;
    } program_erase_controller_state_t;

endpackage
`default_nettype wire

//--- core/program_erase_controller_ctrl.sv
// Register file and sequencing of the flash program/erase controller.
// Assumes a single-cycle register port and a flash array that acknowledges each operation.
`include "program_erase_controller_defines.svh"
`default_nettype none
module program_erase_controller_ctrl #(
    parameter int BLOCKS = 16
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic mem_wr_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic [1:0] mem_size_i,
    input wire logic boot_available_i,
    input wire program_erase_controller_pkg::program_erase_controller_opt_t opt_load_i,
    input wire logic opt_inverse_ok_i,
    input wire logic [BLOCKS-1:0] prot_hit_i,
    input wire logic flash_done_i,
    input wire logic flash_fault_i,
    output program_erase_controller_pkg::program_erase_controller_cmd_t flash_cmd_o,
    output logic bus_err_o,
    output logic boot_select_o,
    output logic irq_o
);

    // The protect status register and its reload are laid out for sixteen blocks only.
    if (BLOCKS != 16) begin : g_bad_blocks
        $error("program_erase_controller_ctrl serves exactly sixteen protect blocks");
    end

    program_erase_controller_pkg::program_erase_controller_state_t s_reg;
    program_erase_controller_pkg::program_erase_controller_state_t s_next;

    // Advances a two-key unlock; a wrong value kills the sequence.
    function automatic program_erase_controller_pkg::program_erase_controller_key_t key_step(input program_erase_controller_pkg::program_erase_controller_key_t cur, input logic [31:0] v);
        program_erase_controller_pkg::program_erase_controller_key_t r;
        r = program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_DEAD;
        if (cur == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_IDLE && v == `PROGRAM_ERASE_CONTROLLER_KEY_FIRST) begin
            r = program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_HALF;
        end else if (cur == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_HALF && v == `PROGRAM_ERASE_CONTROLLER_KEY_SECOND) begin
            r = program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_IDLE;
        end
        return r;
    endfunction

    logic [31:0] status_view;
    logic [31:0] opt_view;
    logic wr_ok;
    logic [31:0] w;
    logic pg_write;
    logic prot_hit;

    always_comb begin
        status_view = 32'h0;
        status_view[`PROGRAM_ERASE_CONTROLLER_ST_BOOTLOCK] = s_reg.boot_lock;
        status_view[`PROGRAM_ERASE_CONTROLLER_ST_MODE] = s_reg.boot_mode;
        status_view[`PROGRAM_ERASE_CONTROLLER_ST_DONE] = s_reg.done_flag;
        status_view[`PROGRAM_ERASE_CONTROLLER_ST_PROT] = s_reg.prot_flag;
        status_view[`PROGRAM_ERASE_CONTROLLER_ST_BUSY] = s_reg.busy;
        opt_view = 32'h0;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_USER_BYTE_ONE_LSB +: 8] = s_reg.opt.user_byte_one;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_USER_BYTE_ZERO_LSB +: 8] = s_reg.opt.user_byte_zero;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_FIXED_LSB +: 2] = `PROGRAM_ERASE_CONTROLLER_OPT_FIXED;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_RSTDLY_LSB +: 2] = s_reg.opt.reset_delay_cfg;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_STBY] = s_reg.opt.standby_reset_ctl;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_WDG] = s_reg.opt.watchdog_hw_enable;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_RDP] = s_reg.opt.read_protect_state;
        opt_view[`PROGRAM_ERASE_CONTROLLER_OPT_ERR] = s_reg.opt.option_mismatch_flag;
    end

    always_comb begin
        s_next = s_reg;
        w = reg_wdata_i;
        s_next.bus_err = 1'b0;
        s_next.cmd.start = 1'b0;
        s_next.rdata = 32'h0;
        prot_hit = |prot_hit_i;
        // Option image is captured once, on the first clock after reset release.
        if (!s_reg.opt_loaded) begin
            s_next.opt = opt_load_i;
            s_next.opt.option_mismatch_flag = ~opt_inverse_ok_i;
            s_next.opt_loaded = 1'b1;
        end
        wr_ok = reg_wr_i && !s_reg.busy;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `PROGRAM_ERASE_CONTROLLER_OFS_STATUS: s_next.rdata = status_view;
                `PROGRAM_ERASE_CONTROLLER_OFS_CTRL: s_next.rdata = s_reg.ctrl;
                `PROGRAM_ERASE_CONTROLLER_OFS_OPT: s_next.rdata = opt_view;
                `PROGRAM_ERASE_CONTROLLER_OFS_WP: s_next.rdata = {16'h0, s_reg.opt.block_protect_bits};
                default: s_next.rdata = 32'h0;
            endcase
        end
        // Operation completion from the array ends busy and clears the go bit.
        if (s_reg.busy && flash_done_i) begin
            s_next.busy = 1'b0;
            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_GO] = 1'b0;
            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_BUFCLR] = 1'b0;
            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_PAGE_BUFFER_LOAD] = 1'b0;
        end
        if (wr_ok) begin
            unique case (reg_addr_i)
                `PROGRAM_ERASE_CONTROLLER_OFS_KEY: begin
                    if (s_reg.main_key == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_DEAD) begin
                        s_next.bus_err = 1'b1;
                    end else begin
                        s_next.main_key = key_step(s_reg.main_key, w);
                        if (s_reg.main_key == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_HALF && w == `PROGRAM_ERASE_CONTROLLER_KEY_SECOND) begin
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_LOCK] = 1'b0;
                        end
                        if (s_next.main_key == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_DEAD) begin
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_LOCK] = 1'b1;
                            s_next.bus_err = 1'b1;
                        end
                    end
                end
                `PROGRAM_ERASE_CONTROLLER_OFS_OPTKEY: begin
                    if (s_reg.opt_key != program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_DEAD) begin
                        s_next.opt_key = key_step(s_reg.opt_key, w);
                        if (s_reg.opt_key == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_HALF && w == `PROGRAM_ERASE_CONTROLLER_KEY_SECOND) begin
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_OPTWE] = 1'b1;
                        end
                    end
                end
                `PROGRAM_ERASE_CONTROLLER_OFS_FASTKEY: begin
                    if (s_reg.fast_key != program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_DEAD) begin
                        s_next.fast_key = key_step(s_reg.fast_key, w);
                        if (s_reg.fast_key == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_HALF && w == `PROGRAM_ERASE_CONTROLLER_KEY_SECOND) begin
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_MODE_LOCK] = 1'b0;
                        end
                    end
                end
                `PROGRAM_ERASE_CONTROLLER_OFS_BOOTKEY: begin
                    if (s_reg.boot_key != program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_DEAD) begin
                        s_next.boot_key = key_step(s_reg.boot_key, w);
                        if (s_reg.boot_key == program_erase_controller_pkg::PROGRAM_ERASE_CONTROLLER_KEY_HALF && w == `PROGRAM_ERASE_CONTROLLER_KEY_SECOND) begin
                            s_next.boot_lock = 1'b0;
                        end
                    end
                end
                `PROGRAM_ERASE_CONTROLLER_OFS_STATUS: begin
                    if (w[`PROGRAM_ERASE_CONTROLLER_ST_DONE]) begin
                        s_next.done_flag = 1'b0;
                    end
                    if (w[`PROGRAM_ERASE_CONTROLLER_ST_PROT]) begin
                        s_next.prot_flag = 1'b0;
                    end
                    if (w[`PROGRAM_ERASE_CONTROLLER_ST_BOOTLOCK]) begin
                        s_next.boot_lock = 1'b1;
                    end
                    if (!s_reg.boot_lock) begin
                        s_next.boot_mode = w[`PROGRAM_ERASE_CONTROLLER_ST_MODE];
                    end
                end
                `PROGRAM_ERASE_CONTROLLER_OFS_CTRL: begin
                    if (!s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_LOCK]) begin
                        s_next.ctrl = (s_reg.ctrl & ~`PROGRAM_ERASE_CONTROLLER_CTRL_WMASK) | (w & `PROGRAM_ERASE_CONTROLLER_CTRL_WMASK);
                        s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_MODE_LOCK] = s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_MODE_LOCK] | w[`PROGRAM_ERASE_CONTROLLER_CT_FAST_MODE_LOCK];
                        s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_OPTWE] = s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_OPTWE] & w[`PROGRAM_ERASE_CONTROLLER_CT_OPTWE];
                        s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_GO] = s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_GO] | w[`PROGRAM_ERASE_CONTROLLER_CT_GO];
                        if (s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_MODE_LOCK]) begin
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_ERASE_SEL] = 1'b0;
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_PROGRAM_SEL] = 1'b0;
                        end
                        if (!s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_OPTWE]) begin
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_OPTION_ERASE_SEL] = 1'b0;
                            s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_OBPG] = 1'b0;
                        end
                        s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_LOCK] = w[`PROGRAM_ERASE_CONTROLLER_CT_LOCK];
                        if (w[`PROGRAM_ERASE_CONTROLLER_CT_GO] || w[`PROGRAM_ERASE_CONTROLLER_CT_BUFCLR] || w[`PROGRAM_ERASE_CONTROLLER_CT_PAGE_BUFFER_LOAD]) begin
                            s_next.busy = 1'b1;
                            s_next.cmd.start = 1'b1;
                            s_next.cmd.addr = s_reg.addr;
                            s_next.cmd.data = s_reg.last_word;
                            s_next.cmd.mode = {w[`PROGRAM_ERASE_CONTROLLER_CT_BUFCLR], w[`PROGRAM_ERASE_CONTROLLER_CT_PAGE_BUFFER_LOAD], w[`PROGRAM_ERASE_CONTROLLER_CT_GO],
                                w[`PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_PROGRAM_SEL], w[`PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_ERASE_SEL]};
                        end
                    end
                end
                `PROGRAM_ERASE_CONTROLLER_OFS_ADDR: s_next.addr = w;
                default: s_next.bus_err = 1'b0;
            endcase
        end else if (reg_wr_i) begin
            s_next.bus_err = 1'b1;
        end
        // Writes to the flash window: half-words program in standard mode, words feed the page buffer only when fast page program is selected.
        pg_write = mem_wr_i && !s_reg.busy && !s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_LOCK];
        if (pg_write && s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_FAST_PAGE_PROGRAM_SEL] && mem_size_i == 2'h2) begin
            s_next.last_word = mem_wdata_i;
        end else if (pg_write && s_reg.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_PG]) begin
            if (mem_size_i != 2'h1) begin
                s_next.bus_err = 1'b1;
            end else if (prot_hit) begin
                s_next.prot_flag = 1'b1;
            end else begin
                s_next.busy = 1'b1;
                s_next.cmd.start = 1'b1;
                s_next.cmd.addr = mem_addr_i;
                s_next.cmd.data = mem_wdata_i;
                s_next.cmd.mode = 5'h0;
            end
        end else if (mem_wr_i) begin
            s_next.bus_err = 1'b1;
        end
        // Array events are applied last so a set wins over a same-cycle clear.
        if (s_reg.busy && flash_done_i) begin
            if (flash_fault_i) begin
                s_next.prot_flag = 1'b1;
            end else begin
                s_next.done_flag = 1'b1;
            end
        end
        s_next.irq = (s_next.done_flag && s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_DONEIE])
            || (s_next.prot_flag && s_next.ctrl[`PROGRAM_ERASE_CONTROLLER_CT_ERROR_IRQ_ENABLE]);
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
            s_reg.boot_lock <= 1'b1;
            s_reg.ctrl <= `PROGRAM_ERASE_CONTROLLER_CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata_o = s_reg.rdata;
    assign flash_cmd_o = s_reg.cmd;
    assign bus_err_o = s_reg.bus_err;
    assign boot_select_o = s_reg.boot_mode & boot_available_i;
    assign irq_o = s_reg.irq;

endmodule
`default_nettype wire

//--- tb/program_erase_controller_ctrl_chk.sv
// Port-level checks of the flash program/erase controller.
// Assumes it is bound to program_erase_controller_ctrl and sees only that module's ports.
`default_nettype none
module program_erase_controller_ctrl_chk #(
    parameter int BLOCKS = 16
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic mem_wr_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    input wire logic [1:0] mem_size_i,
    input wire logic boot_available_i,
    input wire program_erase_controller_pkg::program_erase_controller_opt_t opt_load_i,
    input wire logic opt_inverse_ok_i,
    input wire logic [BLOCKS-1:0] prot_hit_i,
    input wire logic flash_done_i,
    input wire logic flash_fault_i,
    input wire program_erase_controller_pkg::program_erase_controller_cmd_t flash_cmd_o,
    input wire logic bus_err_o,
    input wire logic boot_select_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    wire logic any_wr = reg_wr_i | mem_wr_i;
    wire logic cause = any_wr | flash_done_i;
    sequence s_bad_key;
        reg_wr_i && reg_addr_i == 8'h04 && reg_wdata_i != 32'h45670123 && reg_wdata_i != 32'hcdef89ab;
    endsequence
    sequence s_key_wr;
        reg_wr_i && reg_addr_i == 8'h04;
    endsequence
    a_err_cause: assert property (bus_err_o |-> $past(any_wr))
        else $error("bus error without a write");
    a_start_pulse: assert property (flash_cmd_o.start |=> !flash_cmd_o.start)
        else $error("start pulse longer than one cycle");
    a_start_cause: assert property (flash_cmd_o.start |-> $past(any_wr))
        else $error("start without a write");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(cause) || $past(cause, 2))
        else $error("interrupt rose without cause");
    a_irq_drop: assert property ($fell(irq_o) |-> $past(reg_wr_i) || $past(reg_wr_i, 2))
        else $error("interrupt fell without software write");
    a_boot_gate: assert property (!boot_available_i |-> !boot_select_o)
        else $error("boot selected while unavailable");
    a_key_dead: assert property (s_bad_key ##[1:4] s_key_wr |=> bus_err_o)
        else $error("key write after bad key not refused");
endmodule
bind program_erase_controller_ctrl program_erase_controller_ctrl_chk #(.BLOCKS(BLOCKS)) i_program_erase_controller_ctrl_chk (
    .ref_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .mem_wr_i, .mem_addr_i, .mem_wdata_i, .mem_size_i, .boot_available_i, .opt_load_i,
    .opt_inverse_ok_i, .prot_hit_i, .flash_done_i, .flash_fault_i, .flash_cmd_o, .bus_err_o,
    .boot_select_o, .irq_o
);
`default_nettype wire

//--- tb/program_erase_controller_flash_model.sv
// Behavioural flash array that answers each launched operation.
// Assumes start pulses from the controller's command port.
`default_nettype none
module program_erase_controller_flash_model (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic start_i,
    input wire logic slow_i,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt;
    // An operation takes 3 cycles when prompt and 30 when slow.
    always @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= 0;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt == 1);
            if (start_i) begin
                cnt <= slow_i ? 30 : 3;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench of the flash program/erase controller.
// Assumes the controller, its checker and the flash model are compiled first.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic mem_wr_i = 1'b0;
    logic [1:0] mem_size_i = 2'h1;
    logic [15:0] prot_hit_i = 16'h0;
    logic boot_available_i = 1'b1;
    logic opt_inverse_ok_i = 1'b1;
    logic slow = 1'b0;
    logic fault = 1'b0;
    logic flash_done;
    logic [31:0] reg_rdata_o;
    logic bus_err_o;
    logic boot_select_o;
    logic irq_o;
    logic [31:0] v;
    program_erase_controller_pkg::program_erase_controller_opt_t opt_load_i;
    program_erase_controller_pkg::program_erase_controller_cmd_t flash_cmd_o;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    assign opt_load_i = {8'ha5, 8'h3c, 2'h2, 4'he, 16'hf0f0};
    always #50 ref_clk_i = ~ref_clk_i;
    program_erase_controller_ctrl #(.BLOCKS(16)) i_program_erase_controller_ctrl (
        .ref_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .mem_wr_i, .mem_addr_i(32'h08000402), .mem_wdata_i(32'h1234abcd), .mem_size_i,
        .boot_available_i, .opt_load_i, .opt_inverse_ok_i, .prot_hit_i, .flash_done_i(flash_done),
        .flash_fault_i(fault), .flash_cmd_o, .bus_err_o, .boot_select_o, .irq_o
    );
    program_erase_controller_flash_model i_program_erase_controller_flash_model (
        .ref_clk_i, .arst_n_i, .start_i(flash_cmd_o.start), .slow_i(slow), .done_o(flash_done)
    );
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic keys(input logic [7:0] a);
        wr(a, 32'h45670123);
        reg_wdata_i <= 32'hcdef89ab;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        v = reg_rdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        ck(v, exp);
    endtask
    task automatic mw(input logic [1:0] s, input logic [15:0] h);
        @(posedge ref_clk_i);
        mem_size_i <= s;
        prot_hit_i <= h;
        mem_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        mem_wr_i <= 1'b0;
        #1;
    endtask
    task automatic idle;
        for (int i = 0; i < 60; i++) begin
            rd(8'h0c);
            if (v[0] === 1'b0) break;
        end
        ck({31'h0, v[0]}, 32'h0);
    endtask
    task automatic do_reset;
        arst_n_i <= 1'b0;
        repeat (8) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
    endtask
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            end_of_test;
        end
    end
    initial begin
        do_reset;
        rdc(8'h0c, 32'h00008000);
        rdc(8'h10, 32'h00008080);
        rdc(8'h1c, 32'h0294f356);
        rdc(8'h20, 32'h0000f0f0);
        rdc(8'h30, 32'h0);
        wr(8'h10, 32'h00001000);
        rdc(8'h10, 32'h00008080);
        keys(8'h04);
        wr(8'h10, 32'h00001000);
        rdc(8'h10, 32'h00009000);
        wr(8'h14, 32'h08000400);
        slow <= 1'b1;
        wr(8'h10, 32'h00001042);
        ck(flash_cmd_o.start, 1'b1);
        ck(flash_cmd_o.addr, 32'h08000400);
        wr(8'h10, 32'h00001000);
        ck(bus_err_o, 1'b1);
        wr(8'h14, 32'h08000800);
        ck(bus_err_o, 1'b1);
        rdc(8'h0c, 32'h00008001);
        // The array has taken the slow duration by now; later operations are prompt.
        slow <= 1'b0;
        idle;
        rdc(8'h0c, 32'h00008020);
        rdc(8'h10, 32'h00009002);
        ck(irq_o, 1'b1);
        fault <= 1'b1;
        wr(8'h10, 32'h00001042);
        ck(flash_cmd_o.addr, 32'h08000400);
        idle;
        fault <= 1'b0;
        rdc(8'h0c, 32'h00008030);
        wr(8'h0c, 32'h00000010);
        wr(8'h0c, 32'h0);
        rdc(8'h0c, 32'h00008020);
        wr(8'h0c, 32'h00000020);
        rdc(8'h0c, 32'h00008000);
        ck(irq_o, 1'b0);
        wr(8'h10, 32'h00000401);
        mw(2'h1, 16'h0001);
        ck(flash_cmd_o.start, 1'b0);
        rdc(8'h0c, 32'h00008010);
        ck(irq_o, 1'b1);
        wr(8'h10, 32'h00000001);
        rdc(8'h10, 32'h00008001);
        ck(irq_o, 1'b0);
        wr(8'h0c, 32'h00000010);
        rdc(8'h0c, 32'h00008000);
        mw(2'h2, 16'h0);
        ck(bus_err_o, 1'b1);
        mw(2'h1, 16'h0);
        ck(flash_cmd_o.start, 1'b1);
        ck(flash_cmd_o.addr, 32'h08000402);
        ck(flash_cmd_o.data, 32'h1234abcd);
        idle;
        rdc(8'h0c, 32'h00008020);
        ck(irq_o, 1'b0);
        wr(8'h0c, 32'h00000020);
        keys(8'h24);
        rdc(8'h10, 32'h00000001);
        wr(8'h10, 32'h00010001);
        mw(2'h2, 16'h0);
        ck(bus_err_o, 1'b0);
        wr(8'h10, 32'h00050001);
        ck(flash_cmd_o.data, 32'h1234abcd);
        idle;
        wr(8'h0c, 32'h00000020);
        rdc(8'h10, 32'h00010001);
        wr(8'h10, 32'h00020001);
        rdc(8'h10, 32'h00020001);
        wr(8'h10, 32'h00008000);
        rdc(8'h10, 32'h00008000);
        keys(8'h08);
        rdc(8'h10, 32'h00008200);
        wr(8'h10, 32'h00000236);
        rdc(8'h10, 32'h00008236);
        wr(8'h10, 32'h0);
        rdc(8'h10, 32'h00008000);
        keys(8'h28);
        rdc(8'h0c, 32'h0);
        wr(8'h0c, 32'h00004000);
        rdc(8'h0c, 32'h00004000);
        ck(boot_select_o, 1'b1);
        boot_available_i <= 1'b0;
        @(posedge ref_clk_i);
        #1;
        ck(boot_select_o, 1'b0);
        wr(8'h10, 32'h00000080);
        rdc(8'h10, 32'h00008080);
        wr(8'h04, 32'h00000001);
        ck(bus_err_o, 1'b1);
        wr(8'h04, 32'h45670123);
        ck(bus_err_o, 1'b1);
        rdc(8'h10, 32'h00008080);
        opt_inverse_ok_i <= 1'b0;
        do_reset;
        rdc(8'h1c, 32'h0294f357);
        rdc(8'h0c, 32'h00008000);
        end_of_test;
    end
endmodule
`default_nettype wire
